// [design/fus_defines.svh]
// Timing figures and field layout for the filter update scheduler.
// Assumes inclusion by bare name from design files.
`ifndef FUS_DEFINES_SVH
`define FUS_DEFINES_SVH
`define FUS_NUM_CH       6
`define FUS_CLK_NS       100
`define FUS_MS_NS        1000000
`define FUS_CJ_MS        14'h2710
`define FUS_FILT_W       3
`define FUS_FILT_MAX     3'h5
`define FUS_CJ_OPEN_TEMP 16'h00FA
`define FUS_P0_NORM      9'h0F6
`define FUS_P0_CJ        9'h1F4
`define FUS_P1_NORM      9'h06A
`define FUS_P1_CJ        9'h0DC
`define FUS_P2_NORM      9'h042
`define FUS_P2_CJ        9'h08C
`define FUS_P3_NORM      9'h039
`define FUS_P3_CJ        9'h07A
`define FUS_P4_NORM      9'h01A
`define FUS_P4_CJ        9'h034
`define FUS_P5_NORM      9'h008
`define FUS_P5_CJ        9'h018
`endif

// [design/fus_pkg.sv]
// Types for the filter update scheduler.
// Assumes fus_defines.svh is compiled alongside.
package fus_pkg;
  typedef struct packed {
    logic [13:0]      ms_div;
    logic             ms_tick;
    logic [13:0]      cj_ms;
    logic [1:0]       cj_req;
    logic [1:0]       cj_mode;
    logic [1:0]       cj_seen;
    logic [1:0][15:0] cj_temp;
    logic [5:0][8:0]  cnt;
    logic [5:0][15:0] word;
    logic [5:0]       upd;
    logic [5:0]       err;
    logic [8:0]       mod_period;
  } fus_state_t;
endpackage

// [design/fus_scheduler.sv]
// Six-channel conversion scheduler: per-channel update timing from filter select,
// cold-junction sampling on channels 0 and 5, data word refresh.
// Assumes configuration and converter results come from logic on core_clk.
//
// Contract
// - Three-bit filter select per channel
// - 4.17 Hz: 246 ms, 500 ms
// - 10.0 Hz: 106 ms, 220 ms
// - 16.7 Hz: 66 ms, 140 ms
// - 19.6 Hz: 57 ms, 122 ms
// - 62 Hz: 26 ms, 52 ms
// - 470 Hz: 8 ms, 24 ms
// - Every channel converts concurrently, own converter
// - Module period is slowest enabled channel
// - Every 10 s channels 0,5 sample sensor
// - After sample, channels 0,5 resume normal
// - Channels 1-4 unaffected by sensor sampling
// - All millivolt: never sample the sensors
// - Data word rewritten once per period
// - Open sensor at power-up reads 25 C
`timescale 1ns/100ps
`default_nettype none
`include "fus_defines.svh"

module fus_scheduler
  import fus_pkg::*;
#(
  parameter int MS_CYCLES = `FUS_MS_NS / `FUS_CLK_NS
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [17:0] ch_filter,
  input  wire logic [5:0]  ch_enable,
  input  wire logic [5:0]  ch_is_mv,
  input  wire logic [95:0] conv_data,
  input  wire logic [1:0]  cj_open,
  input  wire logic [31:0] cj_data,
  output logic      [95:0] ch_word,
  output logic      [5:0]  ch_update,
  output logic      [5:0]  ch_cfg_err,
  output logic      [1:0]  cold_junction_sensor_sel,
  output logic      [31:0] cold_junction_sensor_temp,
  output logic      [8:0]  module_period_ms
);

  // Tick divider is only 14 bits wide
  if (MS_CYCLES < 2 || MS_CYCLES > 16384) begin : g_bad_ms
    $error("MS_CYCLES out of range");
  end

  localparam logic [13:0] MS_LAST = 14'(MS_CYCLES - 1);

  function automatic logic [8:0] period_ms(input logic [2:0] f, input logic cj);
    logic [8:0] p;
    p = 9'h000;
    unique case (f)
      3'h0: p = cj ? `FUS_P0_CJ : `FUS_P0_NORM;
      3'h1: p = cj ? `FUS_P1_CJ : `FUS_P1_NORM;
      3'h2: p = cj ? `FUS_P2_CJ : `FUS_P2_NORM;
      3'h3: p = cj ? `FUS_P3_CJ : `FUS_P3_NORM;
      3'h4: p = cj ? `FUS_P4_CJ : `FUS_P4_NORM;
      3'h5: p = cj ? `FUS_P5_CJ : `FUS_P5_NORM;
      default: p = 9'h000;
    endcase
    return p;
  endfunction

  function automatic logic cj_active(input logic [1:0] mode, input int ch);
    return (ch == 0) ? mode[0] : ((ch == 5) ? mode[1] : 1'b0);
  endfunction

  fus_state_t s_q;
  fus_state_t s_d;
  logic [2:0] filt [6];
  logic       any_tc;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [8:0] per;
    logic [8:0] maxp;
    int         ch;
    logic       cj_set;
    per    = 9'h000;
    maxp   = 9'h000;
    ch     = 0;
    cj_set = 1'b0;
    s_d  = s_q;
    for (int i = 0; i < 6; i++) begin
      filt[i] = ch_filter[3*i +: 3];
    end
    any_tc = |(ch_enable & ~ch_is_mv);

    s_d.ms_tick = 1'b0;
    if (s_q.ms_div == MS_LAST) begin
      s_d.ms_div  = 14'h0000;
      s_d.ms_tick = 1'b1;
    end else begin
      s_d.ms_div = s_q.ms_div + 14'h0001;
    end

    if (s_q.ms_tick) begin
      if (s_q.cj_ms == `FUS_CJ_MS - 14'h0001) begin
        s_d.cj_ms = 14'h0000;
        if (any_tc) begin
          s_d.cj_req = 2'b11;
          cj_set     = 1'b1;
        end
      end else begin
        s_d.cj_ms = s_q.cj_ms + 14'h0001;
      end
    end

    s_d.upd = 6'h00;
    for (int i = 0; i < 6; i++) begin
      s_d.err[i] = filt[i] > `FUS_FILT_MAX;
      per = period_ms(filt[i], cj_active(s_q.cj_mode, i));
      if (!ch_enable[i] || s_q.err[i]) begin
        s_d.cnt[i] = 9'h000;
      end else if (s_q.ms_tick) begin
        if (s_q.cnt[i] >= per - 9'h001) begin
          s_d.cnt[i]  = 9'h000;
          s_d.upd[i]  = 1'b1;
          s_d.word[i] = conv_data[16*i +: 16];
        end else begin
          s_d.cnt[i] = s_q.cnt[i] + 9'h001;
        end
      end
      if (ch_enable[i] && !s_q.err[i] && per > maxp) begin
        maxp = per;
      end
    end
    s_d.mod_period = maxp;

    // only channels 0 and 5 switch
    for (int k = 0; k < 2; k++) begin
      ch = (k == 0) ? 0 : 5;
      if (!ch_enable[ch] || !any_tc) begin
        s_d.cj_req[k] = 1'b0;
      end
      if (s_d.upd[ch]) begin
        if (s_q.cj_mode[k]) begin
          s_d.cj_mode[k] = 1'b0;
          s_d.cj_seen[k] = 1'b1;
          if (!cj_open[k]) begin
            s_d.cj_temp[k] = cj_data[16*k +: 16];
          end else if (!s_q.cj_seen[k]) begin
            // fixed value when open at power-up
            s_d.cj_temp[k] = `FUS_CJ_OPEN_TEMP;
          end
        end else if (s_q.cj_req[k] && any_tc) begin
          // switch to the sensor for one period
          s_d.cj_mode[k] = 1'b1;
          // Fresh request beats the clear on entry
          s_d.cj_req[k]  = cj_set;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ch_word                   = s_q.word;
  assign ch_update                 = s_q.upd;
  assign ch_cfg_err                = s_q.err;
  assign cold_junction_sensor_sel  = s_q.cj_mode;
  assign cold_junction_sensor_temp = s_q.cj_temp;
  assign module_period_ms          = s_q.mod_period;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_err_code;
    ##1 1'b1 |-> ch_cfg_err[2] == ($past(ch_filter[8:6]) > `FUS_FILT_MAX);
  endproperty
  a_err_code: assert property (p_err_code) else $error("config error flag wrong");

  property p_word_load;
    ch_update[3] |-> ch_word[63:48] == $past(conv_data[63:48]);
  endproperty
  a_word_load: assert property (p_word_load) else $error("data word not refreshed");

  property p_period_ch1;
    ch_update[1] |-> $past(s_q.cnt[1]) == period_ms($past(ch_filter[5:3]), 1'b0) - 9'h001;
  endproperty
  a_period_ch1: assert property (p_period_ch1) else $error("channel 1 period wrong");

  property p_no_cj_mv;
    (ch_enable & ~ch_is_mv) == 6'h00 |=> !$rose(cold_junction_sensor_sel[0]);
  endproperty
  a_no_cj_mv: assert property (p_no_cj_mv) else $error("sensor sampled in millivolt mode");

  sequence s_cj_enter;
    $rose(cold_junction_sensor_sel[1]);
  endsequence
  property p_cj_cause;
    s_cj_enter |-> $past(s_q.cj_req[1]) && ch_update[5];
  endproperty
  a_cj_cause: assert property (p_cj_cause) else $error("sensor switch without request");

  property p_cj_exit;
    $fell(cold_junction_sensor_sel[0]) |-> ch_update[0];
  endproperty
  a_cj_exit: assert property (p_cj_exit) else $error("sensor released off boundary");

  property p_open_temp;
    $rose(s_q.cj_seen[0]) && $past(cj_open[0]) |-> cold_junction_sensor_temp[15:0] == `FUS_CJ_OPEN_TEMP;
  endproperty
  a_open_temp: assert property (p_open_temp) else $error("open sensor value wrong");

  property p_tick;
    s_q.ms_tick |=> !s_q.ms_tick ##0 s_q.ms_div == 14'h0001;
  endproperty
  a_tick: assert property (p_tick) else $error("millisecond tick misplaced");

  property p_mod_period;
    ##1 ($past(ch_enable[2]) && !$past(ch_cfg_err[2]))
      |-> module_period_ms >= period_ms($past(ch_filter[8:6]), 1'b0);
  endproperty
  a_mod_period: assert property (p_mod_period) else $error("module period below channel 2");

endmodule
`default_nettype wire

// [test/fus_ctrl_model.sv]
// Controller model: latches each data word when the block announces it.
// Assumes block outputs are registered on core_clk.
`timescale 1ns/100ps
`default_nettype none
module fus_ctrl_model (
  input  wire logic        core_clk,
  input  wire logic [5:0]  ch_update,
  input  wire logic [95:0] ch_word,
  output logic      [95:0] image
);
  initial begin
    image = '0;
  end
  always @(posedge core_clk) begin
    for (int i = 0; i < 6; i++) begin
      if (ch_update[i] === 1'b1) begin
        image[16*i +: 16] <= ch_word[16*i +: 16];
      end
    end
  end
endmodule
`default_nettype wire

// [test/tb_filter_update_scheduler.sv]
// Self-checking bench for the filter update scheduler.
// Assumes a 4-cycle millisecond so ten seconds fit the run.
`timescale 1ns/100ps
`default_nettype none
module tb_filter_update_scheduler;
  import fus_pkg::*;
  localparam int MS = 4;
  localparam logic [17:0] F0 = {3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [17:0] ch_filter = F0;
  logic [5:0] ch_enable = 6'h3F;
  logic [5:0] ch_is_mv = 6'h00;
  logic [95:0] conv_data = '0;
  logic [1:0] cj_open = 2'h1;
  logic [31:0] cj_data = 32'h01230456;
  logic [95:0] ch_word, image;
  logic [5:0] ch_update, ch_cfg_err;
  logic [1:0] cj_sel;
  logic [31:0] cj_temp;
  logic [8:0] module_period_ms;
  int num_errors = 0, compares = 0, cyc = 0, gap, sel_cyc = 0, cj_gaps = 0, cj0;
  int last[6];
  logic chk_on = 1'b0;
  logic [5:0] fresh;
  logic [15:0] exp_q[6][$];
  logic [15:0] last_exp[6];
  int nrm[6] = '{246, 106, 66, 57, 26, 8};
  int cjt[6] = '{500, 220, 140, 122, 52, 24};

  fus_scheduler #(.MS_CYCLES(MS)) dut (.core_clk(core_clk), .rst_n(rst_n), .ch_filter(ch_filter),
    .ch_enable(ch_enable), .ch_is_mv(ch_is_mv), .conv_data(conv_data), .cj_open(cj_open),
    .cj_data(cj_data), .ch_word(ch_word), .ch_update(ch_update), .ch_cfg_err(ch_cfg_err),
    .cold_junction_sensor_sel(cj_sel), .cold_junction_sensor_temp(cj_temp),
    .module_period_ms(module_period_ms));
  fus_ctrl_model ctrl (.core_clk(core_clk), .ch_update(ch_update), .ch_word(ch_word), .image(image));

  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic step(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  // Watcher: gap between updates and word contents
  always @(negedge core_clk) begin
    if (cj_sel !== 2'h0) sel_cyc++;
    for (int i = 0; i < 6; i++) begin
      if (!chk_on) last[i] = 0;
      else if (ch_update[i] === 1'b1) begin
        gap = cyc - last[i];
        if (exp_q[i].size() == 0) check("word note", 32'h1, 32'h0);
        else begin
          last_exp[i] = exp_q[i].pop_front();
          check("word", last_exp[i], ch_word[16*i +: 16]);
        end
        if (last[i] != 0 && (i == 0 || i == 5) && gap == cjt[ch_filter[3*i +: 3]] * MS) cj_gaps++;
        else if (last[i] != 0) check("gap", nrm[ch_filter[3*i +: 3]] * MS, gap);
        last[i] = cyc;
      end
    end
  end

  // Driver: new converter word after each update, noted for the watcher
  always @(negedge core_clk) begin
    if (chk_on && ch_update !== 6'h00) begin
      fresh = ch_update;
      @(posedge core_clk);
      #1;
      for (int i = 0; i < 6; i++) begin
        if (fresh[i] === 1'b1) begin
          conv_data[16*i +: 16] = 16'($urandom);
          exp_q[i].push_back(conv_data[16*i +: 16]);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h40D9));
    step(8);
    rst_n = 1'b1;
    ch_filter[5:0] = {3'h7, 3'h6};
    step(2);
    check("cfg_err", 6'h03, ch_cfg_err);
    check("period", 9'h042, module_period_ms);
    ch_filter = {3'h5, 3'h4, 3'h3, 3'h2, 3'h7, 3'h6};
    ch_enable[2] = 1'b0;
    step(2);
    check("period", 9'h039, module_period_ms);
    ch_filter = F0;
    ch_enable = 6'h3F;
    step(2);
    check("cfg_err", 6'h00, ch_cfg_err);
    $display("config test done");
    for (int i = 0; i < 6; i++) begin
      conv_data[16*i +: 16] = 16'($urandom);
      exp_q[i].push_back(conv_data[16*i +: 16]);
    end
    chk_on = 1'b1;
    // Long enough for channel 0 to finish its 500 ms sensor period
    step(10600 * MS);
    check("sensor gaps", 2, cj_gaps);
    check("sensor sel", (500 + 24) * MS, sel_cyc);
    check("sensor temp", {cj_data[31:16], 16'h00FA}, cj_temp);
    check("period", 9'h0F6, module_period_ms);
    for (int i = 0; i < 6; i++) check("image", last_exp[i], image[16*i +: 16]);
    $display("sensor test done");
    ch_is_mv = 6'h3F;
    step(MS * 600);
    sel_cyc = 0;
    cj0 = cj_gaps;
    step(10000 * MS);
    check("mv sel", 0, sel_cyc);
    check("mv gaps", cj0, cj_gaps);
    $display("millivolt test done");
    close_out();
  end
endmodule
`default_nettype wire
